// ==== src/spf_pkg.sv ====
package spf_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Register word addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_TXD = 4'h2;
  localparam logic [3:0] ADDR_RXD = 4'h3;
  localparam logic [3:0] ADDR_RXCNT = 4'h4;
  // Control field positions
  localparam int CTRL_PAR_LSB = 0;
  localparam int CTRL_FLOW_LSB = 2;
  localparam int CTRL_BAUD_LSB = 5;
  // Status bit positions; the top three are sticky, write one to clear
  localparam int ST_TXPEND = 0;
  localparam int ST_TXBUSY = 1;
  localparam int ST_RXAVAIL = 2;
  localparam int ST_NEARFULL = 3;
  localparam int ST_PAUSED = 4;
  localparam int ST_PARERR = 5;
  localparam int ST_FRMERR = 6;
  localparam int ST_OVERRUN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam int unsigned RX_DEPTH = 128;
  localparam int unsigned NEAR_FULL = 100;
  localparam int unsigned DATA_BITS_PLAIN = 8;
  localparam int unsigned DATA_BITS_PARITY = 7;
  localparam logic [2:0] BAUD_MAX = 3'h5;

  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} spf_par_t;
  typedef enum logic [2:0] {FLOW_NONE, FLOW_XON, FLOW_DTR, FLOW_RTS, FLOW_MODEM} spf_flow_t;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} spf_bit_state_t;

  function automatic int unsigned spf_baud(input logic [2:0] sel);
    case (sel)
      3'h0: spf_baud = 4800;
      3'h1: spf_baud = 9600;
      3'h2: spf_baud = 19200;
      3'h3: spf_baud = 38400;
      3'h4: spf_baud = 57600;
      default: spf_baud = 115200;
    endcase
  endfunction

  function automatic logic spf_par_bit(input logic [7:0] data, input logic [1:0] par);
    spf_par_bit = (par == PAR_ODD) ? ~^data[6:0] : ^data[6:0];
  endfunction

  function automatic logic [2:0] spf_last_bit(input logic [1:0] par);
    spf_last_bit = (par == PAR_NONE) ? 3'(DATA_BITS_PLAIN - 1) : 3'(DATA_BITS_PARITY - 1);
  endfunction
endpackage

// ==== src/spf_uart_rx.sv ====
`timescale 1ns/100ps
module spf_uart_rx (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic rxdPin, // Serial input pin
  input wire logic [15:0] bitDiv, // Clocks per bit
  input wire logic [1:0] parMode, // Parity selection
  output logic rxValid, // One-cycle pulse per character
  output logic [7:0] rxData, // Received character
  output logic rxParErr, // Parity bad on this character
  output logic rxFrmErr // Stop bit low on this character
);
  spf_pkg::spf_bit_state_t state, next_state;
  logic rxMeta, rxSync;
  logic [15:0] cnt, next_cnt;
  logic [2:0] idx, next_idx;
  logic [7:0] shift, next_shift;
  logic parBad, next_parBad;
  logic next_rxValid, next_rxParErr, next_rxFrmErr;
  logic [7:0] next_rxData;

  always_comb begin
    next_state = state;
    next_cnt = cnt - 16'h0001;
    next_idx = idx;
    next_shift = shift;
    next_parBad = parBad;
    next_rxValid = 1'b0;
    next_rxData = rxData;
    next_rxParErr = rxParErr;
    next_rxFrmErr = rxFrmErr;
    case (state)
      spf_pkg::ST_IDLE: begin
        next_cnt = {1'b0, bitDiv[15:1]};
        if (!rxSync) begin
          next_state = spf_pkg::ST_START;
        end
      end
      spf_pkg::ST_START: begin
        if (cnt == 16'h0000) begin
          // Mid-bit recheck rejects glitches shorter than half a bit
          next_state = rxSync ? spf_pkg::ST_IDLE : spf_pkg::ST_DATA;
          next_cnt = bitDiv - 16'h0001;
          next_idx = 3'h0;
          next_shift = 8'h00;
        end
      end
      spf_pkg::ST_DATA: begin
        if (cnt == 16'h0000) begin
          next_shift = {rxSync, shift[7:1]};
          next_cnt = bitDiv - 16'h0001;
          next_idx = idx + 3'h1;
          if (idx == spf_pkg::spf_last_bit(parMode)) begin
            next_state = (parMode == spf_pkg::PAR_NONE) ? spf_pkg::ST_STOP : spf_pkg::ST_PARITY;
            if (parMode != spf_pkg::PAR_NONE) begin
              next_shift = {1'b0, rxSync, shift[7:2]};
            end
          end
        end
      end
      spf_pkg::ST_PARITY: begin
        if (cnt == 16'h0000) begin
          next_parBad = rxSync != spf_pkg::spf_par_bit(shift, parMode);
          next_cnt = bitDiv - 16'h0001;
          next_state = spf_pkg::ST_STOP;
        end
      end
      spf_pkg::ST_STOP: begin
        if (cnt == 16'h0000) begin
          next_rxValid = 1'b1;
          next_rxData = shift;
          next_rxParErr = parBad;
          next_rxFrmErr = !rxSync;
          next_parBad = 1'b0;
          next_state = spf_pkg::ST_IDLE;
        end
      end
      default: next_state = spf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
      state <= spf_pkg::ST_IDLE;
      cnt <= 16'h0000;
      idx <= 3'h0;
      shift <= 8'h00;
      parBad <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxParErr <= 1'b0;
      rxFrmErr <= 1'b0;
    end else begin
      rxMeta <= rxdPin;
      rxSync <= rxMeta;
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      shift <= next_shift;
      parBad <= next_parBad;
      rxValid <= next_rxValid;
      rxData <= next_rxData;
      rxParErr <= next_rxParErr;
      rxFrmErr <= next_rxFrmErr;
    end
  end
endmodule

// ==== src/spf_serial_port.sv ====
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module spf_serial_port #(
  parameter int unsigned CLK_HZ = spf_pkg::CLK_HZ,
  parameter int unsigned RX_DEPTH = spf_pkg::RX_DEPTH,
  parameter int unsigned NEAR_FULL = spf_pkg::NEAR_FULL
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [3:0] addr, // Register word address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic rxdPin, // Serial receive pin
  output logic txdPin, // Serial transmit pin
  input wire logic dsrPin, // Data set ready, high is true
  input wire logic ctsPin, // Clear to send, high is true
  output logic dtrPin, // Data terminal ready, high is true
  output logic rtsPin, // Request to send, high is true
  input wire logic [7:0] nvCfg, // Stored settings read at start-up
  output logic nvSave, // Pulse: store nvData
  output logic [7:0] nvData // Settings to store
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam logic [PW:0] NEAR_LVL = (PW + 1)'(NEAR_FULL);
  localparam logic [PW:0] FULL_LVL = (PW + 1)'(RX_DEPTH);

  function automatic logic [15:0] bitDivOf(input logic [2:0] sel);
    bitDivOf = 16'(CLK_HZ / spf_pkg::spf_baud(sel));
  endfunction

  // Out-of-range stored codes fall back to a usable setting
  function automatic logic [7:0] cleanCfg(input logic [7:0] c);
    logic [1:0] p;
    logic [2:0] f;
    logic [2:0] b;
    p = c[spf_pkg::CTRL_PAR_LSB +: 2];
    f = c[spf_pkg::CTRL_FLOW_LSB +: 3];
    b = c[spf_pkg::CTRL_BAUD_LSB +: 3];
    if (p > 2'(spf_pkg::PAR_EVEN)) p = 2'(spf_pkg::PAR_NONE);
    if (f > 3'(spf_pkg::FLOW_MODEM)) f = 3'(spf_pkg::FLOW_NONE);
    if (b > spf_pkg::BAUD_MAX) b = spf_pkg::CTRL_RESET[spf_pkg::CTRL_BAUD_LSB +: 3];
    cleanCfg = {b, f, p};
  endfunction

  // Configuration and status
  logic [1:0] cfgPar, next_cfgPar;
  logic [2:0] cfgFlow, next_cfgFlow;
  logic [2:0] cfgBaud, next_cfgBaud;
  logic cfgLoaded, next_cfgLoaded;
  logic next_nvSave;
  logic [7:0] next_nvData;
  logic paused, next_paused;
  logic parErr, next_parErr;
  logic frmErr, next_frmErr;
  logic overrun, next_overrun;
  // Transmitter
  spf_pkg::spf_bit_state_t txState, next_txState;
  logic [15:0] txCnt, next_txCnt;
  logic [2:0] txIdx, next_txIdx;
  logic [7:0] txShift, next_txShift;
  logic txParBit, next_txParBit;
  logic [7:0] txHold, next_txHold;
  logic txPend, next_txPend;
  logic next_txdPin;
  // Receive buffer
  logic [7:0] mem [RX_DEPTH];
  logic [PW-1:0] wrPtr, next_wrPtr;
  logic [PW-1:0] rdPtr, next_rdPtr;
  logic [PW:0] count, next_count;
  logic nearFull, next_nearFull;
  logic [7:0] next_rdata;
  logic doPush, doPop;
  // Pins
  logic dsrMeta, dsrSync, ctsMeta, ctsSync;
  logic next_dtrPin, next_rtsPin;
  logic txAllowed;
  logic [15:0] bitDiv;
  logic rxValid, rxParErr, rxFrmErr;
  logic [7:0] rxData;
  logic isCtrlChar;
  logic [7:0] ctrlWord;

  assign bitDiv = bitDivOf(cfgBaud);
  assign ctrlWord = {cfgBaud, cfgFlow, cfgPar};

  spf_uart_rx u_rx (
    .clk(clk),
    .nrst(nrst),
    .rxdPin(rxdPin),
    .bitDiv(bitDiv),
    .parMode(cfgPar),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxParErr(rxParErr),
    .rxFrmErr(rxFrmErr)
  );

  // Flow control characters are consumed, not buffered
  assign isCtrlChar = (cfgFlow == 3'(spf_pkg::FLOW_XON)) &&
                      ((rxData == spf_pkg::CHAR_XOFF) || (rxData == spf_pkg::CHAR_XON));
  assign doPush = rxValid && !isCtrlChar && (count != FULL_LVL);
  assign doPop = rd && (addr == spf_pkg::ADDR_RXD) && (count != '0);

  always_comb begin
    case (cfgFlow)
      3'(spf_pkg::FLOW_NONE): txAllowed = 1'b1;
      3'(spf_pkg::FLOW_XON): txAllowed = !paused;
      3'(spf_pkg::FLOW_DTR): txAllowed = dsrSync;
      3'(spf_pkg::FLOW_RTS): txAllowed = ctsSync;
      3'(spf_pkg::FLOW_MODEM): txAllowed = dsrSync && ctsSync;
      default: txAllowed = 1'b1;
    endcase
  end

  always_comb begin
    next_cfgPar = cfgPar;
    next_cfgFlow = cfgFlow;
    next_cfgBaud = cfgBaud;
    next_cfgLoaded = 1'b1;
    next_nvSave = 1'b0;
    next_nvData = nvData;
    next_paused = paused;
    next_parErr = parErr;
    next_frmErr = frmErr;
    next_overrun = overrun;
    if (!cfgLoaded) begin
      // Settings come back from the store on the first edge after reset
      {next_cfgBaud, next_cfgFlow, next_cfgPar} = cleanCfg(nvCfg);
    end else if (wr && addr == spf_pkg::ADDR_CTRL) begin
      {next_cfgBaud, next_cfgFlow, next_cfgPar} = cleanCfg(wdata);
      next_nvSave = 1'b1;
      next_nvData = cleanCfg(wdata);
    end
    if (wr && addr == spf_pkg::ADDR_STAT) begin
      next_parErr = parErr && !wdata[spf_pkg::ST_PARERR];
      next_frmErr = frmErr && !wdata[spf_pkg::ST_FRMERR];
      next_overrun = overrun && !wdata[spf_pkg::ST_OVERRUN];
    end
    // Hardware sets after the clear so a coincident event is kept
    if (rxValid && rxParErr) next_parErr = 1'b1;
    if (rxValid && rxFrmErr) next_frmErr = 1'b1;
    if (rxValid && !isCtrlChar && count == FULL_LVL) next_overrun = 1'b1;
    if (next_cfgFlow != 3'(spf_pkg::FLOW_XON)) begin
      next_paused = 1'b0;
    end else if (rxValid && rxData == spf_pkg::CHAR_XOFF) begin
      next_paused = 1'b1;
    end else if (rxValid && rxData == spf_pkg::CHAR_XON) begin
      next_paused = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgPar <= spf_pkg::CTRL_RESET[spf_pkg::CTRL_PAR_LSB +: 2];
      cfgFlow <= spf_pkg::CTRL_RESET[spf_pkg::CTRL_FLOW_LSB +: 3];
      cfgBaud <= spf_pkg::CTRL_RESET[spf_pkg::CTRL_BAUD_LSB +: 3];
      cfgLoaded <= 1'b0;
      nvSave <= 1'b0;
      nvData <= spf_pkg::CTRL_RESET;
      paused <= 1'b0;
      parErr <= 1'b0;
      frmErr <= 1'b0;
      overrun <= 1'b0;
    end else begin
      cfgPar <= next_cfgPar;
      cfgFlow <= next_cfgFlow;
      cfgBaud <= next_cfgBaud;
      cfgLoaded <= next_cfgLoaded;
      nvSave <= next_nvSave;
      nvData <= next_nvData;
      paused <= next_paused;
      parErr <= next_parErr;
      frmErr <= next_frmErr;
      overrun <= next_overrun;
    end
  end

  always_comb begin
    next_txState = txState;
    next_txCnt = txCnt - 16'h0001;
    next_txIdx = txIdx;
    next_txShift = txShift;
    next_txParBit = txParBit;
    next_txHold = txHold;
    next_txPend = txPend;
    next_txdPin = txdPin;
    // A write while a character is pending is dropped
    if (wr && addr == spf_pkg::ADDR_TXD && !txPend) begin
      next_txHold = wdata;
      next_txPend = 1'b1;
    end
    case (txState)
      spf_pkg::ST_IDLE: begin
        next_txdPin = 1'b1;
        next_txCnt = txCnt;
        // Flow gating is checked only between characters
        if (txPend && txAllowed) begin
          next_txPend = 1'b0;
          next_txShift = txHold;
          next_txParBit = spf_pkg::spf_par_bit(txHold, cfgPar);
          next_txCnt = bitDiv - 16'h0001;
          next_txdPin = 1'b0;
          next_txState = spf_pkg::ST_START;
        end
      end
      spf_pkg::ST_START: begin
        if (txCnt == 16'h0000) begin
          next_txCnt = bitDiv - 16'h0001;
          next_txIdx = 3'h0;
          next_txdPin = txShift[0];
          next_txState = spf_pkg::ST_DATA;
        end
      end
      spf_pkg::ST_DATA: begin
        if (txCnt == 16'h0000) begin
          next_txCnt = bitDiv - 16'h0001;
          next_txIdx = txIdx + 3'h1;
          next_txShift = {1'b0, txShift[7:1]};
          next_txdPin = txShift[1];
          if (txIdx == spf_pkg::spf_last_bit(cfgPar)) begin
            if (cfgPar == spf_pkg::PAR_NONE) begin
              next_txdPin = 1'b1;
              next_txState = spf_pkg::ST_STOP;
            end else begin
              next_txdPin = txParBit;
              next_txState = spf_pkg::ST_PARITY;
            end
          end
        end
      end
      spf_pkg::ST_PARITY: begin
        if (txCnt == 16'h0000) begin
          next_txCnt = bitDiv - 16'h0001;
          next_txdPin = 1'b1;
          next_txState = spf_pkg::ST_STOP;
        end
      end
      spf_pkg::ST_STOP: begin
        if (txCnt == 16'h0000) begin
          next_txCnt = 16'h0000;
          next_txState = spf_pkg::ST_IDLE;
        end
      end
      default: next_txState = spf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txState <= spf_pkg::ST_IDLE;
      txCnt <= 16'h0000;
      txIdx <= 3'h0;
      txShift <= 8'h00;
      txParBit <= 1'b0;
      txHold <= 8'h00;
      txPend <= 1'b0;
      txdPin <= 1'b1;
    end else begin
      txState <= next_txState;
      txCnt <= next_txCnt;
      txIdx <= next_txIdx;
      txShift <= next_txShift;
      txParBit <= next_txParBit;
      txHold <= next_txHold;
      txPend <= next_txPend;
      txdPin <= next_txdPin;
    end
  end

  always_comb begin
    next_wrPtr = doPush ? wrPtr + PW'(1) : wrPtr;
    next_rdPtr = doPop ? rdPtr + PW'(1) : rdPtr;
    next_count = count;
    if (doPush && !doPop) next_count = count + (PW + 1)'(1);
    if (doPop && !doPush) next_count = count - (PW + 1)'(1);
    // Same threshold both ways: room returns as soon as the count falls below NEAR_FULL
    next_nearFull = next_count >= NEAR_LVL;
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        spf_pkg::ADDR_CTRL: next_rdata = ctrlWord;
        spf_pkg::ADDR_STAT: begin
          next_rdata[spf_pkg::ST_TXPEND] = txPend;
          next_rdata[spf_pkg::ST_TXBUSY] = txState != spf_pkg::ST_IDLE;
          next_rdata[spf_pkg::ST_RXAVAIL] = count != '0;
          next_rdata[spf_pkg::ST_NEARFULL] = nearFull;
          next_rdata[spf_pkg::ST_PAUSED] = paused;
          next_rdata[spf_pkg::ST_PARERR] = parErr;
          next_rdata[spf_pkg::ST_FRMERR] = frmErr;
          next_rdata[spf_pkg::ST_OVERRUN] = overrun;
        end
        spf_pkg::ADDR_RXD: next_rdata = (count != '0) ? mem[rdPtr] : 8'h00;
        spf_pkg::ADDR_RXCNT: next_rdata = 8'(count);
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      nearFull <= 1'b0;
      rdata <= 8'h00;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      nearFull <= next_nearFull;
      rdata <= next_rdata;
    end
  end

  // Storage has no reset; unread slots never reach rdata
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= rxData;
    end
  end

  always_comb begin
    case (cfgFlow)
      3'(spf_pkg::FLOW_DTR): begin
        next_dtrPin = !nextNearFull();
        next_rtsPin = 1'b1;
      end
      3'(spf_pkg::FLOW_RTS): begin
        next_dtrPin = 1'b1;
        next_rtsPin = !nextNearFull();
      end
      3'(spf_pkg::FLOW_MODEM): begin
        next_dtrPin = 1'b1;
        next_rtsPin = !nextNearFull();
      end
      default: begin
        next_dtrPin = 1'b1;
        next_rtsPin = 1'b1;
      end
    endcase
  end

  function automatic logic nextNearFull();
    nextNearFull = next_nearFull;
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dsrMeta <= 1'b0;
      dsrSync <= 1'b0;
      ctsMeta <= 1'b0;
      ctsSync <= 1'b0;
      dtrPin <= 1'b1;
      rtsPin <= 1'b1;
    end else begin
      dsrMeta <= dsrPin;
      dsrSync <= dsrMeta;
      ctsMeta <= ctsPin;
      ctsSync <= ctsMeta;
      dtrPin <= next_dtrPin;
      rtsPin <= next_rtsPin;
    end
  end
endmodule

// ==== tb/spf_serial_port_checker.sv ====
`timescale 1ns/100ps
module spf_serial_port_checker #(
  parameter int unsigned CLK_HZ = spf_pkg::CLK_HZ
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic txdPin, // Serial out
  input wire logic dsrPin, // DSR in
  input wire logic ctsPin, // CTS in
  input wire logic dtrPin, // DTR out
  input wire logic rtsPin, // RTS out
  input wire logic [7:0] nvCfg, // Stored settings
  input wire logic nvSave, // Store pulse
  input wire logic [7:0] nvData // Word to store
);
  localparam int unsigned RATE [6] = '{4800, 9600, 19200, 38400, 57600, 115200};
  logic first, txdPrev, inFrame, startEvt, ctrlWr;
  logic [7:0] cfg;
  logic [2:0] flow;
  logic [3:0] dsrLow, ctsLow;
  int unsigned cyc, div;
  function automatic logic [7:0] cleanCfg(input logic [7:0] c);
    cleanCfg = c;
    if (c[1:0] == 2'h3) cleanCfg[1:0] = 2'h0;
    if (c[4:2] > 3'h4) cleanCfg[4:2] = 3'h0;
    if (c[7:5] > 3'h5) cleanCfg[7:5] = 3'h1;
  endfunction
  assign flow = cfg[4:2];
  assign div = CLK_HZ / RATE[cfg[7:5]];
  assign ctrlWr = wr && addr == spf_pkg::ADDR_CTRL;
  // Both formats are ten bits long, so one frame length serves all
  assign startEvt = !inFrame && txdPrev && !txdPin;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first <= 1'b1;
      cfg <= spf_pkg::CTRL_RESET;
      txdPrev <= 1'b1;
      inFrame <= 1'b0;
      cyc <= 0;
      dsrLow <= 4'h0;
      ctsLow <= 4'h0;
    end else begin
      first <= 1'b0;
      if (first || ctrlWr) cfg <= cleanCfg(first ? nvCfg : wdata);
      txdPrev <= txdPin;
      dsrLow <= dsrPin ? 4'h0 : dsrLow + {3'h0, dsrLow != 4'hF};
      ctsLow <= ctsPin ? 4'h0 : ctsLow + {3'h0, ctsLow != 4'hF};
      if (startEvt) begin
        inFrame <= 1'b1;
        cyc <= 1;
      end else if (inFrame) begin
        cyc <= cyc + 1;
        if (cyc == 10 * div - 1) inFrame <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_bit_edge; inFrame && txdPin != txdPrev |-> cyc % div == 0; endproperty
  a_bit_edge: assert property (p_bit_edge) else $error("txd edge off bit boundary");
  property p_stop; inFrame && cyc >= 9 * div |-> txdPin; endproperty
  a_stop: assert property (p_stop) else $error("stop bit not high");
  property p_none_go;
    wr && addr == spf_pkg::ADDR_TXD && flow == spf_pkg::FLOW_NONE && !inFrame && txdPin
      && txdPrev |-> ##[1:5] startEvt;
  endproperty
  a_none_go: assert property (p_none_go) else $error("free mode char not sent");
  property p_dsr_gate;
    startEvt && (flow == spf_pkg::FLOW_DTR || flow == spf_pkg::FLOW_MODEM) |-> dsrLow < 4'h6;
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("sent while dsr false");
  property p_cts_gate;
    startEvt && (flow == spf_pkg::FLOW_RTS || flow == spf_pkg::FLOW_MODEM) |-> ctsLow < 4'h6;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("sent while cts false");
  property p_modem_dtr; (flow == spf_pkg::FLOW_MODEM) [*3] |-> dtrPin; endproperty
  a_modem_dtr: assert property (p_modem_dtr) else $error("dtr false in modem mode");
  property p_dtr_only; (flow != spf_pkg::FLOW_DTR) [*3] |-> dtrPin; endproperty
  a_dtr_only: assert property (p_dtr_only) else $error("dtr false outside its mode");
  property p_rts_only;
    (flow != spf_pkg::FLOW_RTS && flow != spf_pkg::FLOW_MODEM) [*3] |-> rtsPin;
  endproperty
  a_rts_only: assert property (p_rts_only) else $error("rts false outside its modes");
  property p_nv_save; ctrlWr |=> nvSave && nvData == cleanCfg($past(wdata)); endproperty
  a_nv_save: assert property (p_nv_save) else $error("settings not stored");
  property p_nv_only; nvSave |-> $past(ctrlWr); endproperty
  a_nv_only: assert property (p_nv_only) else $error("spurious store pulse");
  c_xon_tx: cover property (startEvt && flow == spf_pkg::FLOW_XON);
  c_dtr_low: cover property (!dtrPin);
  c_modem_rts_low: cover property (!rtsPin && flow == spf_pkg::FLOW_MODEM);
endmodule

bind spf_serial_port spf_serial_port_checker #(.CLK_HZ(CLK_HZ)) i_chk (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .txdPin(txdPin),
  .dsrPin(dsrPin), .ctsPin(ctsPin), .dtrPin(dtrPin), .rtsPin(rtsPin), .nvCfg(nvCfg),
  .nvSave(nvSave), .nvData(nvData)
);

// ==== tb/spf_partner.sv ====
`timescale 1ns/100ps
module spf_partner (
  input wire logic clk, // System clock
  input wire logic txdPin, // Device transmit line
  output logic rxdPin, // Device receive line, idles high
  output logic dsrPin, // Set ready, high is true
  output logic ctsPin // Clear to send, high is true
);
  int unsigned div = 10;
  int unsigned nb = 8;
  logic [1:0] pm = 2'h0;
  logic [7:0] got[$];
  int badFrames = 0;
  initial begin
    rxdPin = 1'b1;
    dsrPin = 1'b1;
    ctsPin = 1'b1;
  end
  task automatic setFmt(input logic [1:0] p, input int unsigned d);
    pm = p;
    div = d;
    nb = (p == 2'h0) ? 8 : 7;
  endtask
  task automatic setLines(input logic d, input logic c);
    @(posedge clk);
    dsrPin <= d;
    ctsPin <= c;
  endtask
  // Messages are single characters, well inside the unflowed length limit
  task automatic sendChar(input logic [7:0] d);
    logic b;
    for (int i = 0; i < nb + ((pm == 2'h0) ? 2 : 3); i++) begin
      b = 1'b1;
      if (i == 0) b = 1'b0;
      else if (i <= nb) b = d[i-1];
      else if (i == nb + 1 && pm != 2'h0) b = (pm == 2'h1) ? ~^d[6:0] : ^d[6:0];
      @(posedge clk);
      rxdPin <= b;
      repeat (div - 1) @(posedge clk);
    end
  endtask
  initial begin : rx_side
    logic [7:0] v;
    logic bad;
    forever begin
      @(negedge txdPin);
      v = 8'h00;
      repeat (div / 2) @(posedge clk);
      bad = txdPin;
      for (int i = 0; i < nb; i++) begin
        repeat (div) @(posedge clk);
        v[i] = txdPin;
      end
      if (pm != 2'h0) begin
        repeat (div) @(posedge clk);
        bad = bad | (txdPin !== ((pm == 2'h1) ? ~^v[6:0] : ^v[6:0]));
      end
      repeat (div) @(posedge clk);
      if (bad || txdPin !== 1'b1) badFrames++;
      got.push_back(v);
    end
  end
endmodule

// ==== tb/spf_serial_port_tb_top.sv ====
`timescale 1ns/100ps
module spf_serial_port_tb_top;
  localparam int unsigned CLK_HZ = 1152000;
  localparam int unsigned RATE [6] = '{4800, 9600, 19200, 38400, 57600, 115200};
  localparam logic [7:0] NV_INIT = 8'hA0;
  logic clk, nrst, wr, rd, txdPin, rxdPin, dsrPin, ctsPin, dtrPin, rtsPin, nvSave;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, nvCfg, nvData;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  spf_serial_port #(.CLK_HZ(CLK_HZ), .RX_DEPTH(8), .NEAR_FULL(6)) i_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rxdPin(rxdPin), .txdPin(txdPin), .dsrPin(dsrPin), .ctsPin(ctsPin), .dtrPin(dtrPin),
    .rtsPin(rtsPin), .nvCfg(nvCfg), .nvSave(nvSave), .nvData(nvData)
  );
  spf_partner i_peer (
    .clk(clk), .txdPin(txdPin), .rxdPin(rxdPin), .dsrPin(dsrPin), .ctsPin(ctsPin)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Every bus task starts and ends just after a rising edge
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic expRd(input logic [3:0] a, input logic [7:0] exp, input string what);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // Read data stand only in this cycle; look at them once settled
    @(negedge clk);
    check(what, exp, rdata);
    @(posedge clk);
  endtask
  task automatic setCfg(input logic [1:0] p, input logic [2:0] f, input logic [2:0] b);
    wrReg(spf_pkg::ADDR_CTRL, {b, f, p});
    i_peer.setFmt(p, CLK_HZ / RATE[b]);
  endtask
  task automatic expTx(input logic [7:0] exp);
    int n;
    n = 0;
    while (i_peer.got.size() == 0 && n < 12 * i_peer.div) begin
      @(posedge clk);
      n++;
    end
    check("tx char", exp, (i_peer.got.size() != 0) ? i_peer.got.pop_front() : 8'hXX);
  endtask
  task automatic flowTest(input logic [2:0] f, input logic dOff, input logic cOff,
                          input logic dtrFull, input logic rtsFull);
    setCfg(2'h0, f, 3'h5);
    i_peer.setLines(dOff, cOff);
    // Let the lowered line pass the input synchroniser before the write
    repeat (3) @(posedge clk);
    wrReg(spf_pkg::ADDR_TXD, 8'h3C);
    // Longer than one frame, so a character sent by mistake would show
    repeat (150) @(posedge clk);
    check("tx while held", 8'h00, 8'(i_peer.got.size()));
    i_peer.setLines(1'b1, 1'b1);
    repeat (15) @(posedge clk);
    i_peer.setLines(dOff, cOff);
    expTx(8'h3C);
    i_peer.setLines(1'b1, 1'b1);
    for (int i = 0; i < 6; i++) i_peer.sendChar(8'h41 + 8'(i));
    repeat (30) @(posedge clk);
    check("dtr at near full", 8'(dtrFull), 8'(dtrPin));
    check("rts at near full", 8'(rtsFull), 8'(rtsPin));
    expRd(spf_pkg::ADDR_STAT, 8'h0C, "status near full");
    expRd(spf_pkg::ADDR_RXD, 8'h41, "rx pop");
    repeat (3) @(posedge clk);
    check("ready with room", 8'h03, {6'h00, dtrPin, rtsPin});
    for (int i = 1; i < 6; i++) expRd(spf_pkg::ADDR_RXD, 8'h41 + 8'(i), "rx drain");
  endtask
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    nvCfg = NV_INIT;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    expRd(spf_pkg::ADDR_CTRL, NV_INIT, "ctrl from store");
    wrReg(spf_pkg::ADDR_CTRL, 8'hFF);
    expRd(spf_pkg::ADDR_CTRL, 8'h20, "ctrl cleaned");
    expRd(4'hF, 8'h00, "unmapped read");
    wrReg(4'h9, 8'hFF);
    i_peer.setLines(1'b0, 1'b0);
    for (int b = 0; b < 6; b++) begin
      setCfg(2'(b % 3), 3'h0, 3'(b));
      wrReg(spf_pkg::ADDR_TXD, 8'hC5 ^ 8'(b));
      expTx((8'hC5 ^ 8'(b)) & ((b % 3 != 0) ? 8'h7F : 8'hFF));
      i_peer.sendChar(8'h9A + 8'(b));
      repeat (2 * CLK_HZ / RATE[b]) @(posedge clk);
      expRd(spf_pkg::ADDR_RXD, (8'h9A + 8'(b)) & ((b % 3 != 0) ? 8'h7F : 8'hFF), "rx char");
    end
    check("peer frame errors", 8'h00, 8'(i_peer.badFrames));
    expRd(spf_pkg::ADDR_STAT, 8'h00, "status idle");
    i_peer.setLines(1'b1, 1'b1);
    setCfg(2'h0, spf_pkg::FLOW_XON, 3'h5);
    i_peer.sendChar(spf_pkg::CHAR_XOFF);
    repeat (30) @(posedge clk);
    wrReg(spf_pkg::ADDR_TXD, 8'h55);
    repeat (200) @(posedge clk);
    check("tx after pause", 8'h00, 8'(i_peer.got.size()));
    expRd(spf_pkg::ADDR_RXCNT, 8'h00, "flow chars kept out");
    expRd(spf_pkg::ADDR_STAT, 8'h11, "status paused");
    i_peer.sendChar(spf_pkg::CHAR_XON);
    expTx(8'h55);
    flowTest(spf_pkg::FLOW_DTR, 1'b0, 1'b1, 1'b0, 1'b1);
    flowTest(spf_pkg::FLOW_RTS, 1'b1, 1'b0, 1'b1, 1'b0);
    flowTest(spf_pkg::FLOW_MODEM, 1'b1, 1'b0, 1'b1, 1'b0);
    summarize();
  end
endmodule
